// >>> host_model.sv
// Host microcontroller model driving the multiplexed bus
`timescale 1ns/10ps
module host_model (
  // Clock
  input wire logic i_mclk,
  // Read data from device
  input wire logic [7:0] i_ad,
  // Bus strobes and data
  output logic o_cs_n,
  output logic o_as,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_ad
);
  initial begin
    o_cs_n = 1'b1;
    {o_as, o_rd, o_wr} = 3'b000;
    o_ad = 8'h00;
  end
  // Address cycle, then one data cycle
  task acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge i_mclk);
    #1;
    o_cs_n = 1'b0;
    o_as = 1'b1;
    o_ad = a;
    @(posedge i_mclk);
    #1;
    o_as = 1'b0;
    o_wr = w;
    o_rd = !w;
    o_ad = w ? d : ~a;
    @(posedge i_mclk);
    #1;
    q = i_ad;
    {o_rd, o_wr, o_cs_n} = 3'b001;
    o_ad = ~o_ad;
  endtask
endmodule

// >>> phone_config.sv
// Host register bank of the digital telephone device
`timescale 1ns/10ps
`include "phone_params.svh"
module phone_config #(
  parameter bit ALAW = 1'b0
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Host bus, address latched on i_as
  input wire logic i_cs_n,
  input wire logic i_as,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_ad,
  output logic [7:0] o_ad,
  output logic o_ad_oe,
  // Gain controls, data-link rate and companding law select
  output logic o_transmit_highpass_enable,
  output logic [2:0] o_rx_filter_gain,
  output logic signed [3:0] o_rx_filter_db,
  output logic [3:0] o_rx_digital_gain,
  output logic [6:0] o_dl_rate_kbps,
  output logic o_alaw,
  // Codec sample strobe and value
  input wire logic [7:0] i_codec_sample,
  output logic o_sample_stb,
  output logic [7:0] o_sample,
  // Control channel
  input wire logic [7:0] i_ctrl_chan_rx,
  output logic [7:0] o_ctrl_chan_tx,
  // Data link FIFO link side
  input wire logic i_dl_rx_push,
  input wire logic [7:0] i_dl_rx_data,
  input wire logic i_dl_tx_pop,
  output logic [7:0] o_dl_tx_data,
  output logic o_dl_tx_valid,
  // Sense/drive ports, open drain
  input wire logic [6:0] i_sense_drive_ports,
  output logic [6:0] o_sense_drive_ports,
  output logic [6:0] o_sense_drive_ports_oe
);
  typedef struct packed {
    logic [7:0] addr;
    logic [`NUM_CTRL_REGS-1:0][7:0] regs;
    logic [7:0] rdata;
    logic oe;
    logic [15:0] div;
    logic stb;
    logic [7:0] smp;
    logic tx_valid;
  } st_t;
  st_t s_q, s_d;
  phone_pkg::host_req_t req;
  phone_pkg::rate_t rate;
  logic rx_pop, rx_empty, tx_push, tx_empty, tx_full, rx_full;
  logic [7:0] rx_fifo_data, tx_fifo_data;
  function automatic logic signed [3:0] filt_db(input logic [2:0] c);
    filt_db = -$signed({1'b0, c});
  endfunction
  function automatic phone_pkg::rate_t rate_sel(input logic [1:0] c);
    case (c)
      2'd0: rate_sel = phone_pkg::RATE_8;
      2'd1: rate_sel = phone_pkg::RATE_16;
      2'd2: rate_sel = phone_pkg::RATE_48;
      default: rate_sel = phone_pkg::RATE_64;
    endcase
  endfunction
  assign req.addr = s_q.addr;
  assign req.wdata = i_ad;
  assign req.wr = !i_cs_n && i_wr;
  assign req.rd = !i_cs_n && i_rd;
  assign tx_push = req.wr && req.addr == `ADDR_FIFO;
  assign rx_pop = req.rd && req.addr == `ADDR_FIFO;
  assign rate = rate_sel(s_q.regs[`ADDR_DATA_RATE][1:0]);
  phone_fifo u_tx_fifo (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_push(tx_push), .i_data(i_ad),
    .i_pop(i_dl_tx_pop), .o_data(tx_fifo_data), .o_empty(tx_empty),
    .o_full(tx_full)
  );
  phone_fifo u_rx_fifo (
    .i_mclk(i_mclk), .i_reset(i_reset), .i_push(i_dl_rx_push),
    .i_data(i_dl_rx_data), .i_pop(rx_pop), .o_data(rx_fifo_data),
    .o_empty(rx_empty), .o_full(rx_full)
  );
  always_comb begin
    s_d = s_q;
    s_d.stb = 1'b0;
    if (!i_cs_n && i_as) begin
      s_d.addr = i_ad;
    end
    if (req.wr && req.addr < 8'(`NUM_CTRL_REGS) &&
        req.addr != `ADDR_FIFO) begin
      s_d.regs[req.addr[3:0]] = req.wdata;
    end
    s_d.oe = req.rd;
    if (req.addr == `ADDR_FIFO) begin
      s_d.rdata = rx_fifo_data;
    end else if (req.addr == `ADDR_CTRL_CHAN) begin
      s_d.rdata = i_ctrl_chan_rx;
    end else if (req.addr == `ADDR_SENSE) begin
      s_d.rdata = {1'b0, i_sense_drive_ports};
    end else if (req.addr < 8'(`NUM_CTRL_REGS)) begin
      s_d.rdata = s_q.regs[req.addr[3:0]];
    end else begin
      s_d.rdata = 8'h00;
    end
    if (s_q.div == 16'(`SAMPLE_DIV - 1)) begin
      s_d.div = 16'h0000;
      s_d.stb = 1'b1;
      s_d.smp = i_codec_sample;
    end else begin
      s_d.div = s_q.div + 16'h0001;
    end
    s_d.tx_valid = !tx_empty;
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_transmit_highpass_enable <= 1'b0;
      o_rx_filter_gain <= 3'h0;
      o_rx_filter_db <= 4'h0;
      o_rx_digital_gain <= 4'h0;
      o_dl_rate_kbps <= 7'h08;
      o_alaw <= ALAW;
      o_ctrl_chan_tx <= 8'h00;
      o_sense_drive_ports_oe <= 7'h00;
    end else begin
      o_transmit_highpass_enable <= s_d.regs[`ADDR_RX_GAIN][`BIT_HPF];
      o_rx_filter_gain <= s_d.regs[`ADDR_RX_GAIN][`RFG_HI:`RFG_LO];
      o_rx_filter_db <= filt_db(s_d.regs[`ADDR_RX_GAIN][`RFG_HI:`RFG_LO]);
      o_rx_digital_gain <= s_d.regs[`ADDR_RX_GAIN][`RDG_HI:`RDG_LO];
      o_alaw <= ALAW;
      o_ctrl_chan_tx <= s_d.regs[`ADDR_CTRL_CHAN];
      o_sense_drive_ports_oe <= ~s_d.regs[`ADDR_SENSE][6:0];
      case (rate)
        phone_pkg::RATE_8: o_dl_rate_kbps <= 7'h08;
        phone_pkg::RATE_16: o_dl_rate_kbps <= 7'h10;
        phone_pkg::RATE_48: o_dl_rate_kbps <= 7'h30;
        phone_pkg::RATE_64: o_dl_rate_kbps <= 7'h40;
        default: o_dl_rate_kbps <= 7'h08;
      endcase
    end
  end
  always_ff @(posedge i_mclk) begin
    o_dl_tx_data <= tx_fifo_data;
  end
  assign o_ad = s_q.rdata;
  assign o_ad_oe = s_q.oe;
  assign o_sample_stb = s_q.stb;
  assign o_sample = s_q.smp;
  assign o_dl_tx_valid = s_q.tx_valid;
  assign o_sense_drive_ports = 7'h00;
  a_hpf_follows: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_transmit_highpass_enable == s_q.regs[`ADDR_RX_GAIN][7])
    else $error("highpass enable mismatch");
  a_filter_gain: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rx_filter_gain == 3'h7 |-> o_rx_filter_db == -4'sd7)
    else $error("filter gain map wrong");
  a_filter_field: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rx_filter_gain == s_q.regs[`ADDR_RX_GAIN][6:4])
    else $error("filter field mismatch");
  a_digital_field: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_rx_digital_gain == s_q.regs[`ADDR_RX_GAIN][3:0])
    else $error("digital gain mismatch");
  a_gain_write: assert property (@(posedge i_mclk) disable iff (i_reset)
    req.wr && req.addr == 8'h08 |=> s_q.regs[8] == $past(i_ad))
    else $error("gain register write lost");
  a_gain_read: assert property (@(posedge i_mclk) disable iff (i_reset)
    req.rd && req.addr == 8'h08 && !req.wr |=> o_ad_oe && o_ad == s_q.regs[8])
    else $error("gain register read wrong");
  a_sample_rate: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_sample_stb |=> !o_sample_stb [*8])
    else $error("sample strobe too fast");
  a_alaw_fixed: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_alaw == ALAW) else $error("law changed");
  a_rate_legal: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_dl_rate_kbps inside {7'h08, 7'h10, 7'h30, 7'h40})
    else $error("illegal rate");
  c_gain_write: cover property (@(posedge i_mclk) req.wr && req.addr == 8'h08);
  c_fifo_push: cover property (@(posedge i_mclk) tx_push);
  a_oe_follows: assert property (@(posedge i_mclk) disable iff (i_reset)
    req.rd |=> o_ad_oe)
    else $error("read enable missing");
  a_unmap_read: assert property (@(posedge i_mclk) disable iff (i_reset)
    req.rd && req.addr > `ADDR_FIFO |=> o_ad == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_read: assert property (@(posedge i_mclk) disable iff (i_reset)
    req.rd && req.addr == `ADDR_CTRL_CHAN |=> o_ad == $past(i_ctrl_chan_rx))
    else $error("control channel read wrong");
  a_ctrl_tx_follows: assert property (@(posedge i_mclk) disable iff (i_reset)
    o_ctrl_chan_tx == s_q.regs[`ADDR_CTRL_CHAN])
    else $error("control channel drive mismatch");
  a_fifo_head_read: assert property (@(posedge i_mclk) disable iff (i_reset)
    rx_pop && !rx_empty |=> o_ad == $past(rx_fifo_data))
    else $error("fifo read data wrong");
  a_tx_valid: assert property (@(posedge i_mclk) disable iff (i_reset)
    !tx_empty |=> o_dl_tx_valid)
    else $error("transmit valid missing");
  c_sample: cover property (@(posedge i_mclk) o_sample_stb);
  c_gain_read: cover property (@(posedge i_mclk) req.rd && req.addr == 8'h08);
  c_rx_full: cover property (@(posedge i_mclk) rx_full);
endmodule

// >>> phone_config_tb.sv
// Self-checking bench for the phone register bank
`timescale 1ns/10ps
module phone_config_tb;
  logic clk, rst, cs_n, as, rd, wr, oe, transmit_highpass_enable, alaw, stb, rxp, pop, txv;
  logic [7:0] adi, ado, q, cct, ccr, txd, smp, rxd;
  logic [2:0] rfg;
  logic signed [3:0] db;
  logic [3:0] rdg;
  logic [6:0] rate, sdi, sdo, sdoe;
  int error_cnt = 0;
  int compares = 0;
  int n;
  int rt[4] = '{8, 16, 48, 64};
  host_model hm (.i_mclk(clk), .i_ad(ado), .o_cs_n(cs_n), .o_as(as),
    .o_rd(rd), .o_wr(wr), .o_ad(adi));
  phone_config #(.ALAW(1'b1)) uut (.i_mclk(clk), .i_reset(rst),
    .i_cs_n(cs_n), .i_as(as), .i_rd(rd), .i_wr(wr), .i_ad(adi),
    .o_ad(ado), .o_ad_oe(oe), .o_transmit_highpass_enable(transmit_highpass_enable),
    .o_rx_filter_gain(rfg), .o_rx_filter_db(db), .o_rx_digital_gain(rdg),
    .o_dl_rate_kbps(rate), .o_alaw(alaw), .i_codec_sample(8'h5a),
    .o_sample_stb(stb), .o_sample(smp), .i_ctrl_chan_rx(ccr),
    .o_ctrl_chan_tx(cct), .i_dl_rx_push(rxp), .i_dl_rx_data(rxd),
    .i_dl_tx_pop(pop), .o_dl_tx_data(txd), .o_dl_tx_valid(txv),
    .i_sense_drive_ports(sdi), .o_sense_drive_ports(sdo),
    .o_sense_drive_ports_oe(sdoe));
  task chk(string nm, logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task cyc;
    @(posedge clk);
    #1;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #320000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    {rst, rxp, pop} = 3'b100;
    {rxd, ccr} = 16'h0000;
    sdi = 7'h00;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    hm.acc(0, 8'h08, 8'h00, q);
    chk("rst08", 8'h00, q);
    chk("rate", 8'h08, {1'b0, rate});
    chk("alaw", 8'h01, {7'h0, alaw});
    $display("test reset done");
    for (n = 0; n < 8; n++) begin
      hm.acc(1, 8'h08, {n[0], n[2:0], ~n[3:0]}, q);
      chk("hpf", {7'h0, n[0]}, {7'h0, transmit_highpass_enable});
      chk("rfg", {5'h0, n[2:0]}, {5'h0, rfg});
      chk("db", {4'h0, 4'(0 - n)}, {4'h0, db});
      chk("rdg", {4'h0, ~n[3:0]}, {4'h0, rdg});
      chk("oe", 8'h00, {7'h0, oe});
      hm.acc(0, 8'h08, 8'h00, q);
      chk("rd08", {n[0], n[2:0], ~n[3:0]}, q);
      chk("oe", 8'h01, {7'h0, oe});
    end
    $display("test gain done");
    for (n = 0; n < 4; n++) begin
      hm.acc(1, 8'h09, 8'(n), q);
      cyc;
      chk("rate", 8'(rt[n]), {1'b0, rate});
    end
    $display("test rate done");
    ccr = 8'h3c;
    hm.acc(1, 8'h0b, 8'ha5, q);
    chk("cctx", 8'ha5, cct);
    hm.acc(0, 8'h0b, 8'h00, q);
    chk("ccrx", 8'h3c, q);
    sdi = 7'h33;
    hm.acc(1, 8'h0c, 8'h55, q);
    chk("sdoe", 8'h2a, {1'b0, sdoe});
    chk("sdo", 8'h00, {1'b0, sdo});
    hm.acc(0, 8'h0c, 8'h00, q);
    chk("sdi", 8'h33, q);
    $display("test ports done");
    for (n = 0; n < 12; n++) begin
      cyc;
      rxp = 1'b1;
      rxd = 8'h10 + 8'(n);
    end
    cyc;
    rxp = 1'b0;
    for (n = 0; n < 11; n++) begin
      hm.acc(0, 8'h0d, 8'h00, q);
      chk("rxff", 8'h10 + 8'(n), q);
    end
    hm.acc(0, 8'h0e, 8'h00, q);
    chk("unmap", 8'h00, q);
    hm.acc(1, 8'h0d, 8'hc1, q);
    hm.acc(1, 8'h0d, 8'hc2, q);
    repeat (2) cyc;
    chk("txv", 8'h01, {7'h0, txv});
    chk("txd", 8'hc1, txd);
    for (n = 0; n < 2; n++) begin
      pop = 1'b1;
      cyc;
      pop = 1'b0;
      repeat (2) cyc;
      if (n == 0) chk("txd", 8'hc2, txd);
    end
    chk("txv", 8'h00, {7'h0, txv});
    $display("test fifo done");
    n = 0;
    while (stb !== 1'b1 && n < 40000) begin
      cyc;
      n++;
    end
    n = 0;
    do begin
      cyc;
      n++;
    end while (stb !== 1'b1 && n < 40000);
    chk("period", 8'h01, {7'h0, n == 31250});
    cyc;
    chk("sample", 8'h5a, smp);
    $display("test sample done");
    tally_and_finish;
  end
endmodule

// >>> phone_fifo.sv
// Eleven-byte FIFO for the data-link path
`timescale 1ns/10ps
`include "phone_params.svh"
module phone_fifo (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_push,
  input wire logic [7:0] i_data,
  // Drain side
  input wire logic i_pop,
  output logic [7:0] o_data,
  output logic o_empty,
  output logic o_full
);
  typedef struct packed {
    logic [3:0] wp;
    logic [3:0] rp;
    logic [3:0] cnt;
  } st_t;
  st_t s_q, s_d;
  logic [7:0] mem [0:`FIFO_DEPTH-1];
  logic do_push, do_pop;
  function automatic logic [3:0] inc(input logic [3:0] p);
    inc = (p == 4'(`FIFO_DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction
  assign do_push = i_push && (s_q.cnt != 4'(`FIFO_DEPTH));
  assign do_pop = i_pop && (s_q.cnt != 4'h0);
  always_comb begin
    s_d = s_q;
    if (do_push) begin
      s_d.wp = inc(s_q.wp);
    end
    if (do_pop) begin
      s_d.rp = inc(s_q.rp);
    end
    s_d.cnt = s_q.cnt + {3'h0, do_push} - {3'h0, do_pop};
  end
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
    if (do_push) begin
      mem[s_q.wp] <= i_data;
    end
  end
  assign o_data = mem[s_q.rp];
  assign o_empty = (s_q.cnt == 4'h0);
  assign o_full = (s_q.cnt == 4'(`FIFO_DEPTH));
  a_fifo_bound: assert property (@(posedge i_mclk) disable iff (i_reset)
    s_q.cnt <= 4'(`FIFO_DEPTH)) else $error("fifo count over depth");
endmodule

// >>> phone_params.svh
// Constants for the phone gain and host configuration block
`ifndef PHONE_PARAMS_SVH
`define PHONE_PARAMS_SVH
`define ADDR_RX_GAIN 8'h08
`define ADDR_FIFO 8'h0d
`define ADDR_CTRL_CHAN 8'h0b
`define ADDR_SENSE 8'h0c
`define ADDR_DATA_RATE 8'h09
`define NUM_CTRL_REGS 13
`define FIFO_DEPTH 11
`define BIT_HPF 7
`define RFG_HI 6
`define RFG_LO 4
`define RDG_HI 3
`define RDG_LO 0
`define RX_GAIN_RESET 8'h00
`define MCLK_HZ 250000000
`define SAMPLE_HZ 8000
`define SAMPLE_DIV (`MCLK_HZ / `SAMPLE_HZ)
`endif

// >>> phone_pkg.sv
// Types for the phone gain and host configuration block
package phone_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } host_req_t;
  typedef enum logic [3:0] {
    RATE_8 = 4'b0001,
    RATE_16 = 4'b0010,
    RATE_48 = 4'b0100,
    RATE_64 = 4'b1000
  } rate_t;
endpackage
